// ### design/ias_map.vh
`ifndef IAS_MAP_VH
`define IAS_MAP_VH
// Register byte addresses on the APB side
`define IAS_REG_CTRL 12'h000
`define IAS_REG_DAC 12'h004
`define IAS_REG_ADC 12'h008
`define IAS_REG_STAT 12'h00C
// Control byte field positions
`define IAS_CTRL_OUT_EN 6
`define IAS_CTRL_MODE_HI 5
`define IAS_CTRL_MODE_LO 4
`define IAS_CTRL_AUTOINC 2
// Reserved bits 7 and 3 always store as zero
`define IAS_CTRL_MASK 8'h77
// Reset values
`define IAS_CTRL_RESET 8'h00
`define IAS_DAC_RESET 8'h00
`define IAS_ADC_RESET 8'h80
// Sign flip for differential results, first SAR trial
`define IAS_DIFF_FLIP 8'h80
// Clock and conversion oscillator rates
`define IAS_CLK_KHZ 10000
`define IAS_OSC_KHZ 1000
// Fixed address part, arbitrary value
`define IAS_FIXED_ADDR 4'h5
`endif

// ### design/ias_sequencer.v
// What this block does
// - Third write byte sets output level
// - Control flag switches output buffer
// - Active output holds until next byte
// - Buffer held during every input conversion
// - Read address starts a conversion
// - Trigger at ack clock fall, overlap shift
// - Sample channel, 8-bit successive approximation
// - Differential pairs give two's complement
// - Store result, then auto-increment channel
// - First read byte is previous result
// - Result register resets to 80 hex
// - Low select: internal oscillator, drive pin
// - High select: pin released, external clock
// - Data stable while clock high
// - Start and stop are data edges
// - Matching address and every write byte get acknowledged
// - Ack holds data low through clock high
// - Master nack ends read, data released
// - Address first, direction bit decides
// - Write ends on stop or restart
// - Second write byte is control register
// - Bit 6 enables output and oscillator
// - Excess channel clamps, increment wraps
// - Reset clears control, output off
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`include "ias_map.vh"
module ias_sequencer #(
  parameter CLK_KHZ = `IAS_CLK_KHZ,
  parameter OSC_KHZ = `IAS_OSC_KHZ
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Serial bus, open drain
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  // Address and oscillator straps
  input wire hw_addr_bit_lo,
  input wire hw_addr_bit_mid,
  input wire hw_addr_bit_hi,
  input wire osc_source_select,
  // Oscillator pin, two-way
  input wire oscillator_pin_in,
  output wire oscillator_pin_out,
  output wire oscillator_pin_oe_n,
  // Converter analog front end
  output reg [7:0] dac_tap,
  output reg buffer_enable,
  output reg buffer_hold,
  output reg sample_strobe,
  output reg autozero_tick,
  output reg [1:0] mux_channel,
  output reg [1:0] mux_mode,
  input wire comp_in
);

  // Half period of the internal oscillator, in clk cycles
  localparam integer OSC_HALF_I = CLK_KHZ / (2 * OSC_KHZ);
  localparam [7:0] OSC_HALF = (OSC_HALF_I < 1) ? 8'h01 : OSC_HALF_I[7:0];
  // Serial protocol states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_AACK = 3'd2;
  localparam [2:0] ST_WR = 3'd3;
  localparam [2:0] ST_WACK = 3'd4;
  localparam [2:0] ST_RD = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;
  // Highest channel for each input mode
  function [1:0] max_ch;
    input [1:0] mode;
    begin
      case (mode)
        2'd0: max_ch = 2'd3;
        2'd1: max_ch = 2'd2;
        2'd2: max_ch = 2'd2;
        default: max_ch = 2'd1;
      endcase
    end
  endfunction
  // Clamp a requested channel to what the mode offers
  function [1:0] clamp_ch;
    input [1:0] ch;
    input [1:0] mode;
    begin
      clamp_ch = (ch > max_ch(mode)) ? max_ch(mode) : ch;
    end
  endfunction

  // Pin order: scl, sda, osc in, addr lo, mid, hi, select
  wire [6:0] pins;
  assign pins = {osc_source_select, hw_addr_bit_hi, hw_addr_bit_mid,
                 hw_addr_bit_lo, oscillator_pin_in, sda_in, scl_in};

  reg [6:0] s1_q; // First stage, read only by s2
  reg [6:0] s2_q;
  reg [6:0] s3_q;
  reg [6:0] lvl_q; // Accepted levels
  reg [6:0] prv_q; // Levels one cycle back

  // Three-stage synchroniser; a level counts when stages 2 and 3 agree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 7'h03;
      s2_q <= 7'h03;
      s3_q <= 7'h03;
      lvl_q <= 7'h03;
      prv_q <= 7'h03;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & lvl_q);
      prv_q <= lvl_q;
    end
  end

  // Bus events from the filtered levels
  wire scl_rise = lvl_q[0] & ~prv_q[0];
  wire scl_fall = ~lvl_q[0] & prv_q[0];
  // Data edges with clock high are conditions, not data
  wire start_ev = lvl_q[0] & prv_q[0] & prv_q[1] & ~lvl_q[1];
  wire stop_ev = lvl_q[0] & prv_q[0] & ~prv_q[1] & lvl_q[1];
  wire ext_sel = lvl_q[6];
  wire [6:0] my_addr = {`IAS_FIXED_ADDR, lvl_q[5:3]};
  // Protocol and register state
  reg [2:0] st_q;
  reg [3:0] bcnt_q; // Bits taken in the current byte
  reg [7:0] rx_q; // Receive shifter
  reg [7:0] tx_q; // Transmit shifter
  reg drv_q; // Pull data low when set
  reg mack_q; // Master ack level, low means more
  reg widx_q; // Clear until control byte stored
  reg [7:0] ctrl_q;
  reg [7:0] dac_q;
  reg ctrl_ld_q; // Control just loaded
  reg go_q; // Conversion trigger pulse
  reg [7:0] adc_q; // Result awaiting transmission
  reg busy_q;
  // Open drain: value is always low, enable low while pulling
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_q;

  // Zero wait state slave
  assign pready = 1'b1;
  wire hit = (paddr == `IAS_REG_CTRL) | (paddr == `IAS_REG_DAC) |
             (paddr == `IAS_REG_ADC) | (paddr == `IAS_REG_STAT);
  assign pslverr = psel & penable & ~hit;
  wire apb_wr = psel & penable & pwrite & hit;

  // Serial slave and register writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      bcnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      drv_q <= 1'b0;
      mack_q <= 1'b1;
      widx_q <= 1'b0;
      ctrl_q <= `IAS_CTRL_RESET;
      dac_q <= `IAS_DAC_RESET;
      ctrl_ld_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      ctrl_ld_q <= 1'b0;
      go_q <= 1'b0;
      // Software may also set control and output level
      if (apb_wr && paddr == `IAS_REG_CTRL) begin
        ctrl_q <= pwdata[7:0] & `IAS_CTRL_MASK;
        ctrl_ld_q <= 1'b1;
      end
      if (apb_wr && paddr == `IAS_REG_DAC) begin
        dac_q <= pwdata[7:0];
      end
      if (start_ev) begin
        // Start or repeated start always wins
        st_q <= ST_ADDR;
        bcnt_q <= 4'h0;
        drv_q <= 1'b0;
        widx_q <= 1'b0;
      end else if (stop_ev) begin
        st_q <= ST_IDLE;
        drv_q <= 1'b0;
      end else begin
        // Data is sampled on the rising clock edge
        if (scl_rise) begin
          if (st_q == ST_ADDR || st_q == ST_WR) begin
            rx_q <= {rx_q[6:0], lvl_q[1]};
            bcnt_q <= bcnt_q + 4'h1;
          end
          if (st_q == ST_RACK) begin
            mack_q <= lvl_q[1];
          end
        end
        // Data is changed only on the falling clock edge
        if (scl_fall) begin
          case (st_q)
            ST_ADDR: begin
              if (bcnt_q == 4'h8) begin
                if (rx_q[7:1] == my_addr) begin
                  st_q <= ST_AACK;
                  drv_q <= 1'b1;
                end else begin
                  st_q <= ST_IDLE;
                end
              end
            end
            ST_AACK: begin
              bcnt_q <= 4'h0;
              if (rx_q[0]) begin
                // Read: send old result, start new conversion
                st_q <= ST_RD;
                tx_q <= adc_q;
                drv_q <= ~adc_q[7];
                go_q <= 1'b1;
              end else begin
                st_q <= ST_WR;
                drv_q <= 1'b0;
              end
            end
            ST_WR: begin
              if (bcnt_q == 4'h8) begin
                st_q <= ST_WACK;
                drv_q <= 1'b1;
                if (!widx_q) begin
                  ctrl_q <= rx_q & `IAS_CTRL_MASK;
                  ctrl_ld_q <= 1'b1;
                  widx_q <= 1'b1;
                end else begin
                  dac_q <= rx_q;
                end
              end
            end
            ST_WACK: begin
              st_q <= ST_WR;
              bcnt_q <= 4'h0;
              drv_q <= 1'b0;
            end
            ST_RD: begin
              if (bcnt_q == 4'h7) begin
                // Release for the master's ack bit
                st_q <= ST_RACK;
                drv_q <= 1'b0;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                drv_q <= ~tx_q[6];
                bcnt_q <= bcnt_q + 4'h1;
              end
            end
            ST_RACK: begin
              bcnt_q <= 4'h0;
              if (!mack_q) begin
                st_q <= ST_RD;
                tx_q <= adc_q;
                drv_q <= ~adc_q[7];
                go_q <= 1'b1;
              end else begin
                // Nack: keep data released until stop
                st_q <= ST_IDLE;
                drv_q <= 1'b0;
              end
            end
            default: begin
              st_q <= ST_IDLE;
              drv_q <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Oscillator runs while output enabled or converting
  wire osc_run = ctrl_q[`IAS_CTRL_OUT_EN] | busy_q;
  reg [7:0] ocnt_q;
  reg osc_q;

  // Internal oscillator divided from clk
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ocnt_q <= 8'h00;
      osc_q <= 1'b0;
    end else if (!osc_run || ext_sel) begin
      ocnt_q <= 8'h00;
      osc_q <= 1'b0;
    end else if (ocnt_q == OSC_HALF - 8'h01) begin
      ocnt_q <= 8'h00;
      osc_q <= ~osc_q;
    end else begin
      ocnt_q <= ocnt_q + 8'h01;
    end
  end

  // Internal tick at each oscillator rise, external from pin rising edges
  wire int_tick = osc_run & ~ext_sel & ~osc_q & (ocnt_q == OSC_HALF - 8'h01);
  wire ext_tick = ext_sel & lvl_q[2] & ~prv_q[2];
  wire tick = int_tick | ext_tick;
  assign oscillator_pin_out = osc_q;
  assign oscillator_pin_oe_n = ext_sel;

  reg [7:0] trial_q; // SAR trial code
  reg [7:0] mask_q; // Bit now being decided
  reg [1:0] ch_q;
  reg settle_q; // Set from sampling until the first tick
  wire [1:0] mode = ctrl_q[`IAS_CTRL_MODE_HI:`IAS_CTRL_MODE_LO];
  // Differential when every channel is a pair, or channel 2 of mode 2
  wire is_diff = (mode == 2'd1) | (mode == 2'd3) |
                 ((mode == 2'd2) & (ch_q == 2'd2));
  wire [7:0] decided = comp_in ? trial_q : (trial_q & ~mask_q);
  // Successive approximation sequencer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trial_q <= 8'h00;
      mask_q <= 8'h00;
      busy_q <= 1'b0;
      settle_q <= 1'b0;
      adc_q <= `IAS_ADC_RESET;
      ch_q <= 2'd0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      if (ctrl_ld_q) begin
        ch_q <= clamp_ch(ctrl_q[1:0], mode);
      end
      if (go_q) begin
        // Take the sample; a new trigger restarts any run
        busy_q <= 1'b1;
        sample_strobe <= 1'b1;
        trial_q <= `IAS_DIFF_FLIP;
        mask_q <= `IAS_DIFF_FLIP;
        settle_q <= 1'b1;
      end else if (busy_q && tick && settle_q) begin
        // A tick may follow the trigger at once; the tap is not shown yet
        settle_q <= 1'b0;
      end else if (busy_q && tick) begin
        if (mask_q[0]) begin
          busy_q <= 1'b0;
          // Straight binary, sign flipped for pairs
          adc_q <= is_diff ? (decided ^ `IAS_DIFF_FLIP) : decided;
          if (ctrl_q[`IAS_CTRL_AUTOINC]) begin
            ch_q <= (ch_q >= max_ch(mode)) ? 2'd0 : ch_q + 2'd1;
          end
        end else begin
          trial_q <= decided | {1'b0, mask_q[7:1]};
          mask_q <= {1'b0, mask_q[7:1]};
        end
      end
    end
  end

  // Analog front end drive, all from flops
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_tap <= `IAS_DAC_RESET;
      buffer_enable <= 1'b0;
      buffer_hold <= 1'b0;
      autozero_tick <= 1'b0;
      mux_channel <= 2'd0;
      mux_mode <= 2'd0;
    end else begin
      // Shared ladder shows the trial code while converting
      dac_tap <= busy_q ? trial_q : dac_q;
      buffer_enable <= ctrl_q[`IAS_CTRL_OUT_EN];
      buffer_hold <= busy_q | go_q;
      autozero_tick <= tick & ctrl_q[`IAS_CTRL_OUT_EN];
      // Clamped here too, so channel and mode change together
      mux_channel <= clamp_ch(ch_q, mode);
      mux_mode <= mode;
    end
  end

  // Read data captured in the setup cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        `IAS_REG_CTRL: prdata <= {24'h000000, ctrl_q};
        `IAS_REG_DAC: prdata <= {24'h000000, dac_q};
        `IAS_REG_ADC: prdata <= {24'h000000, adc_q};
        `IAS_REG_STAT: prdata <= {24'h000000, ext_sel, busy_q, st_q, ch_q, osc_run};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ### verif/ias_seq_checker.sv
`timescale 1ns/10ps
module ias_seq_checker (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register bus
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Serial and oscillator pins
  input wire scl_in,
  input wire sda_oe_n,
  input wire osc_source_select,
  input wire oscillator_pin_oe_n,
  // Converter front end
  input wire buffer_enable,
  input wire buffer_hold,
  input wire sample_strobe,
  input wire autozero_tick,
  input wire [1:0] mux_channel,
  input wire [1:0] mux_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Sampling takes the hold at once
  a_hold_at_sample: assert property (sample_strobe |-> ##[0:1] buffer_hold)
    else $error("hold not set at sample");
  // Hold lasts nine cycles at least, never stuck in hold
  a_conv_length: assert property ($rose(buffer_hold) |=> buffer_hold[*8] ##[1:400]
    !buffer_hold) else $error("conversion length wrong");
  a_sample_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe too long");
  // Our data only moves while the clock is low
  a_data_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data moved with clock high");
  // Refresh ticks need the buffer on
  a_tick_gated: assert property (autozero_tick |-> buffer_enable && !$past(autozero_tick))
    else $error("refresh tick misplaced");
  // Zero wait states, error only outside the map
  a_apb_answer: assert property (psel && penable |-> pready && pslverr ==
    (paddr[1:0] != 2'b00 || paddr > 12'h00C)) else $error("register bus answer wrong");
  a_chan_clamp: assert property (mux_mode == 2'd3 |-> mux_channel <= 2'd1)
    else $error("channel beyond pair count");
  // Strap needs a few edges to pass the synchroniser
  a_osc_free: assert property (osc_source_select && $past(osc_source_select, 5)
    && $past(reset_n, 5) |-> oscillator_pin_oe_n) else $error("oscillator pin driven");
endmodule
bind ias_sequencer ias_seq_checker u_chk (.clk, .reset_n, .psel, .penable, .paddr, .pready,
  .pslverr, .scl_in, .sda_oe_n, .osc_source_select, .oscillator_pin_oe_n, .buffer_enable,
  .buffer_hold, .sample_strobe, .autozero_tick, .mux_channel, .mux_mode);

// ### verif/ias_bus_master.sv
`timescale 1ns/10ps
module ias_bus_master (
  // Clock
  input wire clk,
  // Bus lines
  input wire sda,
  output logic scl_q,
  output logic sda_q
);
  // Both lines idle high, clock still between frames
  initial begin
    scl_q = 1'b1;
    sda_q = 1'b1;
  end
  // Whole cycles of the fast clock
  task automatic rep(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: long low phase, as the slave answers through a synchroniser
  task automatic bitx(input logic b, output logic r);
    scl_q <= 1'b0;
    rep(2);
    sda_q <= b;
    rep(3);
    scl_q <= 1'b1;
    rep(1);
    r = sda;
    rep(2);
  endtask
  // Start only from an idle bus
  task automatic start;
    sda_q <= 1'b0;
    rep(6);
  endtask
  // Data rises with the clock high
  task automatic stop;
    scl_q <= 1'b0;
    rep(2);
    sda_q <= 1'b0;
    rep(3);
    scl_q <= 1'b1;
    rep(3);
    sda_q <= 1'b1;
    rep(8);
  endtask
  // Byte MSB first; ninth clock carries the acknowledge
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], b);
      r[i] = b;
    end
    bitx(m_ack, ack);
  endtask
endmodule

// ### verif/tb_ias_sequencer.sv
`timescale 1ns/10ps
`include "ias_map.vh"
module tb_ias_sequencer;
  // Clock, reset and register bus
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr;
  // Serial lines with pull-up
  wire scl, sda_m, sda_out, sda_oe_n;
  wire sda = sda_m & (sda_oe_n | sda_out);
  // Oscillator pin and analog side
  logic osc_sel = 1'b0;
  logic osc_ext = 1'b0;
  logic comp_in = 1'b0;
  logic [3:0] div_q = 4'h0;
  wire osc_out, osc_oe_n, buffer_enable, buffer_hold, sample_strobe;
  wire osc_pin = osc_oe_n ? osc_ext : osc_out;
  wire [7:0] dac_tap;
  wire [1:0] mux_channel;
  logic [7:0] vin [4] = '{8'h3C, 8'hC3, 8'h5A, 8'h90};
  logic [7:0] vin_q = 8'h00;
  logic [31:0] r;
  logic e, a;
  int n_errors = 0;
  int compares = 0;
  int osc_edges = 0;
  localparam logic [6:0] DEV = {`IAS_FIXED_ADDR, 3'b101};
  always #50 clk = ~clk;
  // Conversion clock edges seen on the oscillator pin
  always @(posedge osc_pin) osc_edges++;
  // External clock near 1 MHz, ideal comparator on the held level
  always @(posedge clk) begin
    div_q <= (div_q == 4'h4) ? 4'h0 : div_q + 4'h1;
    if (div_q == 4'h4) osc_ext <= ~osc_ext;
    if (sample_strobe) vin_q <= vin[mux_channel];
    comp_in <= (vin_q >= dac_tap);
  end
  ias_sequencer uut (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
    .hw_addr_bit_lo(1'b1), .hw_addr_bit_mid(1'b0), .hw_addr_bit_hi(1'b1),
    .osc_source_select(osc_sel), .oscillator_pin_in(osc_pin),
    .oscillator_pin_out(osc_out), .oscillator_pin_oe_n(osc_oe_n),
    .dac_tap, .buffer_enable, .buffer_hold, .sample_strobe, .autozero_tick(),
    .mux_channel, .mux_mode(), .comp_in
  );
  ias_bus_master m (.clk, .sda, .scl_q(scl), .sda_q(sda_m));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access, answer taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Serial write of control and level
  task automatic wr(input logic [7:0] c, input logic [7:0] l);
    logic [7:0] x;
    m.start;
    m.xfer({DEV, 1'b0}, 1'b1, x, a);
    chk(a, 0);
    m.xfer(c, 1'b1, x, a);
    chk(a, 0);
    m.xfer(l, 1'b1, x, a);
    chk(a, 0);
    m.stop;
  endtask
  // Serial read of one byte, then wait out the conversion
  task automatic rd(input logic [7:0] exp);
    logic [7:0] x;
    m.start;
    m.xfer({DEV, 1'b1}, 1'b1, x, a);
    chk(a, 0);
    m.xfer(8'hFF, 1'b1, x, a);
    chk(x, exp);
    m.stop;
    for (int i = 0; i < 400 && buffer_hold !== 1'b0; i++) @(posedge clk);
    chk(buffer_hold, 1'b0);
  endtask
  // Verdict
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, `IAS_REG_CTRL, 32'h0);
    chk(r, `IAS_CTRL_RESET);
    apb(1'b0, `IAS_REG_ADC, 32'h0);
    chk(r, `IAS_ADC_RESET);
    chk(buffer_enable, 1'b0);
    chk(osc_edges, 0);
    apb(1'b1, 12'h010, 32'hFF);
    chk(e, 1'b1);
    apb(1'b1, `IAS_REG_CTRL, 32'hCC);
    apb(1'b0, `IAS_REG_CTRL, 32'h0);
    chk(r, 32'h44);
    $display("test registers done");
    wr(8'h44, 8'hA5);
    chk(dac_tap, 8'hA5);
    chk(buffer_enable, 1'b1);
    chk(osc_oe_n, 1'b0);
    chk(osc_edges > 0, 1'b1);
    apb(1'b0, `IAS_REG_DAC, 32'h0);
    chk(r, 32'hA5);
    m.start;
    m.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, r[7:0], a);
    chk(a, 1'b1);
    m.stop;
    $display("test serial write done");
    rd(`IAS_ADC_RESET);
    chk(mux_channel, 2'd1);
    rd(vin[0]);
    chk(dac_tap, 8'hA5);
    $display("test single reads done");
    osc_sel <= 1'b1;
    wr(8'h37, 8'h5A);
    chk(mux_channel, 2'd1);
    chk(osc_oe_n, 1'b1);
    chk(buffer_enable, 1'b0);
    rd(vin[1]);
    chk(mux_channel, 2'd0);
    rd(vin[1] ^ `IAS_DIFF_FLIP);
    chk(dac_tap, 8'h5A);
    $display("test differential done");
    wr(8'h26, 8'h5A);
    rd(vin[0] ^ `IAS_DIFF_FLIP);
    chk(mux_channel, 2'd0);
    rd(vin[2] ^ `IAS_DIFF_FLIP);
    $display("test mixed mode done");
    end_sim;
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule
